// [usc_params.svh]
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// Register bus geometry.
`define USC_AW 8
`define USC_DIV_W 8

// Register byte offsets.
`define USC_OFS_TXSC 8'h00
`define USC_OFS_RXSC 8'h04
`define USC_OFS_DIV 8'h08
`define USC_OFS_TXDATA 8'h0c
`define USC_OFS_RXDATA 8'h10

// Field positions of transmit_status_control.
`define USC_TX_CLOCK_SOURCE_SELECT 7
`define USC_TX_NINE 6
`define USC_TX_EN 5
`define USC_TX_SYNC 4
`define USC_TX_HIGH_SPEED_SELECT 2
`define USC_TX_SHIFT_REG_EMPTY 1
`define USC_TX_NINTH 0

// Field positions of receive_status_control.
`define USC_RX_SERIAL_PORT_ENABLE 7
`define USC_RX_NINE 6
`define USC_RX_SINGLE_RECEIVE_ENABLE 5
`define USC_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define USC_RX_ADDRESS_DETECT_ENABLE 3
`define USC_RX_FRAMING_ERROR 2
`define USC_RX_OVERRUN_ERROR 1
`define USC_RX_NINTH 0

// Valid flag position in the receive data word.
`define USC_RXD_VALID 8

// Reset values.
`define USC_TXSC_RST 8'h02
`define USC_RXSC_RST 8'h00
`define USC_DIV_RST 8'h00

// Generator ticks per bit, minus one, and the centre sample tick.
`define USC_LAST_HI 5'd7
`define USC_LAST_LO 5'd31
`define USC_MID_HI 5'd4
`define USC_MID_LO 5'd16

`endif

// [usc_pkg.sv]
package usc_pkg;

  // Transmit sequencer states.
  typedef enum logic [1:0] {
    USC_TX_IDLE,
    USC_TX_START,
    USC_TX_DATA,
    USC_TX_STOP
  } usc_txs_e;

  // Receive sequencer states.
  typedef enum logic {
    USC_RX_IDLE,
    USC_RX_BIT
  } usc_rxs_e;

  // Whole state of the top module.
  typedef struct packed {
    logic clock_source_select;
    logic tx9;
    logic transmit_enable;
    logic sync_mode;
    logic high_speed_select;
    logic transmit_ninth_bit;
    logic serial_port_enable;
    logic rx9;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error;
    logic overrun_error;
    logic receive_ninth_bit;
    logic [7:0] div;
    usc_txs_e txst;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic [4:0] tph;
    usc_rxs_e rxst;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic [4:0] rph;
    logic [7:0] rdat;
    logic rvalid;
    logic sclk;
    logic ck_d;
    logic tck_o;
    logic tck_oe;
    logic rdt_o;
    logic rdt_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } usc_top_s;

  // State of the majority voter.
  typedef struct packed {
    logic [2:0] smp;
  } usc_maj_s;

endpackage

// [usc_if.sv]
`timescale 1ns/1ps

// Baud generator link: new divisor, restart strobe and tick back.
interface usc_brg_if #(parameter int W = 8);
  logic [W-1:0] div;
  logic restart;
  logic tick;
  modport ctl (output div, output restart, input tick);
  modport gen (input div, input restart, output tick);
endinterface

// Majority voter link: sample strobe, pin level and voted level.
interface usc_maj_if;
  logic sample;
  logic din;
  logic vote;
  modport ctl (output sample, output din, input vote);
  modport vtr (input sample, input din, output vote);
endinterface

// [usc_brg.sv]
`timescale 1ns/1ps

// Free-running divisor timer behind a divide-by-two prescaler.
module usc_brg #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  usc_brg_if.gen bus
);
  typedef struct packed {
    logic pre;
    logic [W-1:0] cnt;
  } usc_brg_s;

  usc_brg_s r;
  usc_brg_s n;

  // One tick every 2*(divisor+1) clocks.
  assign bus.tick = r.pre & (r.cnt == '0);

  // A divisor write restarts the count at once, so the new rate needs no wrap.
  always_comb begin
    n = r;
    n.pre = ~r.pre;
    if (bus.restart) begin
      n.pre = 1'b0;
      n.cnt = bus.div;
    end else if (bus.tick) begin
      n.cnt = bus.div;
    end else if (r.pre) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule

// [usc_maj.sv]
`timescale 1ns/1ps

// Keeps the last three pin samples and votes two out of three.
module usc_maj
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  usc_maj_if.vtr bus
);

  usc_maj_s r;
  usc_maj_s n;

  // The vote filters a single-sample glitch on the line.
  assign bus.vote = (r.smp[0] & r.smp[1]) | (r.smp[1] & r.smp[2]) | (r.smp[0] & r.smp[2]);

  always_comb begin
    n = r;
    if (bus.sample) begin
      n.smp = {r.smp[1:0], bus.din};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule

// [usc_top.sv]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "usc_params.svh"

// Contract
// - Async full duplex, sync master, sync slave.
// - Port enable hands pins to the port.
// - Clock source picks master or slave in sync.
// - Nine-bit selects, separate for receive and transmit.
// - High-speed bit changes async divider.
// - Sync mode ignores the high-speed bit.
// - Received ninth bit held; parity is software's.
// - Single receive runs one frame in sync master, then clears.
// - Continuous receive enables; overrides single receive.
// - Async nine-bit address detect loads only ninth-bit-set frames.
// - Framing error flag follows each frame.
// - Overrun flag clears only by clearing continuous receive.
// - Dedicated free-running eight-bit divisor timer.
// - Generator rate used only when clocking ourselves.
// - Divisor write restarts the generator at once.
// - Rates: divide by 64, 16, 4 times divisor+1.
// - Async receive pin voted from three samples; sync receive takes the pin once per rising clock.
module usc_top
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`USC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_or_clock_pin_i,
  output logic transmit_or_clock_pin_o,
  output logic transmit_or_clock_pin_oe,
  input wire logic receive_or_data_pin_i,
  output logic receive_or_data_pin_o,
  output logic receive_or_data_pin_oe
);

  usc_top_s r;
  usc_top_s n;

  usc_brg_if #(.W(`USC_DIV_W)) brg_bus ();
  usc_maj_if maj_bus ();

  logic setup;
  logic access;
  logic addr_hit;
  logic wr_txsc;
  logic wr_rxsc;
  logic wr_div;
  logic wr_tx;
  logic rd_rx;
  logic tick;
  logic master;
  logic rx_on;
  logic tx_busy;
  logic tx_allowed;
  logic rise;
  logic fall;
  logic [4:0] last;
  logic [4:0] mid;
  logic [3:0] tnb;
  logic [3:0] rnb;
  logic [7:0] txsc_rd;
  logic [7:0] rxsc_rd;

  // Bus decode: zero-wait slave, answer registered from the setup cycle.
  assign setup = psel & ~penable;
  assign access = psel & penable & r.pready;
  assign addr_hit = (paddr == `USC_OFS_TXSC) | (paddr == `USC_OFS_RXSC) |
                    (paddr == `USC_OFS_DIV) | (paddr == `USC_OFS_TXDATA) |
                    (paddr == `USC_OFS_RXDATA);
  assign wr_txsc = access & pwrite & (paddr == `USC_OFS_TXSC);
  assign wr_rxsc = access & pwrite & (paddr == `USC_OFS_RXSC);
  assign wr_div = access & pwrite & (paddr == `USC_OFS_DIV);
  assign wr_tx = access & pwrite & (paddr == `USC_OFS_TXDATA);
  assign rd_rx = access & ~pwrite & (paddr == `USC_OFS_RXDATA);

  // Status images as software sees them; bit 3 of the transmit word reads zero.
  assign txsc_rd = {r.clock_source_select, r.tx9, r.transmit_enable, r.sync_mode, 1'b0, r.high_speed_select,
                    (r.txst == USC_TX_IDLE), r.transmit_ninth_bit};
  assign rxsc_rd = {r.serial_port_enable, r.rx9, r.single_receive_enable, r.continuous_receive_enable, r.address_detect_enable, r.framing_error, r.overrun_error, r.receive_ninth_bit};

  // Baud generator: the written value goes straight in with the restart.
  assign brg_bus.div = wr_div ? pwdata[7:0] : r.div;
  assign brg_bus.restart = wr_div;
  assign tick = brg_bus.tick;

  // Mode decode.
  assign master = r.sync_mode & r.clock_source_select;
  assign rx_on = r.serial_port_enable & r.sync_mode & (r.continuous_receive_enable | (r.single_receive_enable & master));
  assign tx_busy = (r.txst != USC_TX_IDLE);
  assign tx_allowed = r.serial_port_enable & r.transmit_enable & ~rx_on;
  assign tnb = r.tx9 ? 4'd9 : 4'd8;
  assign rnb = r.rx9 ? 4'd9 : 4'd8;
  assign last = r.high_speed_select ? `USC_LAST_HI : `USC_LAST_LO;
  assign mid = r.high_speed_select ? `USC_MID_HI : `USC_MID_LO;

  // Sync clock edges: our own divided clock as master, the pin as slave.
  // The pin is taken as synchronous, so a one-flop delay gives a clean edge.
  assign rise = master ? (tick & ~r.sclk & (rx_on | tx_busy)) :
                (transmit_or_clock_pin_i & ~r.ck_d);
  assign fall = master ? (tick & r.sclk) : (~transmit_or_clock_pin_i & r.ck_d);

  // Three samples around the bit centre feed the voter.
  assign maj_bus.sample = tick & ~r.sync_mode & (r.rxst == USC_RX_BIT) &
                          (r.rph >= mid - 5'd1) & (r.rph <= mid + 5'd1);
  assign maj_bus.din = receive_or_data_pin_i;

  usc_brg #(.W(`USC_DIV_W)) u_brg (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(brg_bus)
  );

  usc_maj u_maj (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(maj_bus)
  );

  // Next-state logic for the bus slave, both sequencers and the pins.
  always_comb begin
    logic dl;
    logic [8:0] dd;
    dl = 1'b0;
    dd = 9'h000;
    n = r;

    // Bus answer, prepared in the setup cycle.
    n.pready = setup;
    n.pslverr = setup & ~addr_hit;
    n.prdata = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        `USC_OFS_TXSC: n.prdata = {24'h00_0000, txsc_rd};
        `USC_OFS_RXSC: n.prdata = {24'h00_0000, rxsc_rd};
        `USC_OFS_DIV: n.prdata = {24'h00_0000, r.div};
        `USC_OFS_RXDATA: n.prdata = {23'h00_0000, r.rvalid, r.rdat};
        default: n.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes; read-only status bits are not touched, except overrun, cleared when continuous receive is written zero.
    if (wr_txsc) begin
      n.clock_source_select = pwdata[`USC_TX_CLOCK_SOURCE_SELECT];
      n.tx9 = pwdata[`USC_TX_NINE];
      n.transmit_enable = pwdata[`USC_TX_EN];
      n.sync_mode = pwdata[`USC_TX_SYNC];
      n.high_speed_select = pwdata[`USC_TX_HIGH_SPEED_SELECT];
      n.transmit_ninth_bit = pwdata[`USC_TX_NINTH];
    end
    if (wr_rxsc) begin
      n.serial_port_enable = pwdata[`USC_RX_SERIAL_PORT_ENABLE];
      n.rx9 = pwdata[`USC_RX_NINE];
      n.single_receive_enable = pwdata[`USC_RX_SINGLE_RECEIVE_ENABLE];
      n.continuous_receive_enable = pwdata[`USC_RX_CONTINUOUS_RECEIVE_ENABLE];
      n.address_detect_enable = pwdata[`USC_RX_ADDRESS_DETECT_ENABLE];
      if (!pwdata[`USC_RX_CONTINUOUS_RECEIVE_ENABLE]) begin
        n.overrun_error = 1'b0;
      end
    end
    if (wr_div) begin
      n.div = pwdata[7:0];
    end
    if (rd_rx) begin
      n.rvalid = 1'b0;
    end

    // Transmit sequencer. Sync shifts one bit per clock, async frames it.
    case (r.txst)
      USC_TX_IDLE: begin
        // A data write while busy is dropped; software polls the empty flag.
        if (wr_tx & tx_allowed) begin
          n.tsh = {(r.tx9 ? r.transmit_ninth_bit : 1'b1), pwdata[7:0]};
          n.tcnt = 4'd0;
          n.tph = 5'd0;
          n.txst = r.sync_mode ? USC_TX_DATA : USC_TX_START;
        end
      end
      USC_TX_START: begin
        if (tick) begin
          n.tph = (r.tph == last) ? 5'd0 : r.tph + 5'd1;
          if (r.tph == last) begin
            n.txst = USC_TX_DATA;
          end
        end
      end
      USC_TX_DATA: begin
        if (r.sync_mode) begin
          if (fall) begin
            n.tsh = {1'b0, r.tsh[8:1]};
            n.tcnt = r.tcnt + 4'd1;
            if (r.tcnt == tnb - 4'd1) begin
              n.txst = USC_TX_IDLE;
            end
          end
        end else if (tick) begin
          n.tph = (r.tph == last) ? 5'd0 : r.tph + 5'd1;
          if (r.tph == last) begin
            n.tsh = {1'b0, r.tsh[8:1]};
            n.tcnt = r.tcnt + 4'd1;
            if (r.tcnt == tnb - 4'd1) begin
              n.txst = USC_TX_STOP;
            end
          end
        end
      end
      USC_TX_STOP: begin
        if (tick) begin
          n.tph = (r.tph == last) ? 5'd0 : r.tph + 5'd1;
          if (r.tph == last) begin
            n.txst = USC_TX_IDLE;
          end
        end
      end
      default: n.txst = USC_TX_IDLE;
    endcase
    // Losing the enable, or a receive taking the line, aborts the frame.
    if (!tx_allowed) begin
      n.txst = USC_TX_IDLE;
    end

    // Receive sequencer.
    if (r.sync_mode) begin
      n.rxst = USC_RX_IDLE;
      n.rph = 5'd0;
      if (!rx_on) begin
        n.rcnt = 4'd0;
      end else if (rise) begin
        n.rsh = {receive_or_data_pin_i, r.rsh[8:1]};
        n.rcnt = r.rcnt + 4'd1;
        if (r.rcnt == rnb - 4'd1) begin
          n.rcnt = 4'd0;
          dl = 1'b1;
          dd = {receive_or_data_pin_i, r.rsh[8:1]};
          n.framing_error = 1'b0;
          if (!r.continuous_receive_enable) begin
            n.single_receive_enable = 1'b0;
          end
        end
      end
    end else if (!(r.serial_port_enable & r.continuous_receive_enable)) begin
      n.rxst = USC_RX_IDLE;
      n.rcnt = 4'd0;
    end else begin
      case (r.rxst)
        USC_RX_IDLE: begin
          // A low level on a tick is taken as the start edge.
          if (tick & ~receive_or_data_pin_i) begin
            n.rxst = USC_RX_BIT;
            n.rph = 5'd1;
            n.rcnt = 4'd0;
          end
        end
        USC_RX_BIT: begin
          if (tick) begin
            n.rph = (r.rph == last) ? 5'd0 : r.rph + 5'd1;
            if (r.rph == last) begin
              n.rcnt = r.rcnt + 4'd1;
              if (r.rcnt == 4'd0) begin
                // A start bit that votes high was a glitch.
                if (maj_bus.vote) begin
                  n.rxst = USC_RX_IDLE;
                end
              end else if (r.rcnt <= rnb) begin
                n.rsh = {maj_bus.vote, r.rsh[8:1]};
              end else begin
                n.rxst = USC_RX_IDLE;
                n.framing_error = ~maj_bus.vote;
                dl = 1'b1;
                dd = r.rsh;
              end
            end
          end
        end
        default: n.rxst = USC_RX_IDLE;
      endcase
    end

    // Delivery: address filter, then load or flag overrun. A new frame
    // beats a same-cycle read, so the flag set wins over its clear.
    if (dl) begin
      if (!(~r.sync_mode & r.rx9 & r.address_detect_enable) | dd[8]) begin
        if (n.rvalid) begin
          n.overrun_error = 1'b1;
        end else begin
          n.rdat = r.rx9 ? dd[7:0] : dd[8:1];
          n.receive_ninth_bit = r.rx9 ? dd[8] : 1'b0;
          n.rvalid = 1'b1;
        end
      end
    end

    // Master clock idles low and toggles on generator ticks.
    if (!(master & r.serial_port_enable)) begin
      n.sclk = 1'b0;
    end else if (rise) begin
      n.sclk = 1'b1;
    end else if (fall) begin
      n.sclk = 1'b0;
    end
    n.ck_d = transmit_or_clock_pin_i;

    // Pin drive, registered so every output comes from a flop.
    if (!n.serial_port_enable) begin
      n.tck_o = 1'b0;
      n.tck_oe = 1'b0;
      n.rdt_o = 1'b0;
      n.rdt_oe = 1'b0;
    end else if (!n.sync_mode) begin
      n.tck_oe = 1'b1;
      n.tck_o = (n.txst == USC_TX_START) ? 1'b0 :
                (n.txst == USC_TX_DATA) ? n.tsh[0] : 1'b1;
      n.rdt_o = 1'b0;
      n.rdt_oe = 1'b0;
    end else begin
      n.tck_oe = n.clock_source_select;
      n.tck_o = n.clock_source_select & n.sclk;
      n.rdt_oe = (n.txst != USC_TX_IDLE);
      n.rdt_o = n.tsh[0];
    end
  end

  // All state in one register; reset leaves every register at its reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.div <= `USC_DIV_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign transmit_or_clock_pin_o = r.tck_o;
  assign transmit_or_clock_pin_oe = r.tck_oe;
  assign receive_or_data_pin_o = r.rdt_o;
  assign receive_or_data_pin_oe = r.rdt_oe;

endmodule

// [usc_props.sv]
`timescale 1ns/1ps
`include "usc_params.svh"

// Checks bus answers and pin ownership against a mirror of the control writes.
module usc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`USC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmit_or_clock_pin_oe,
  input wire logic receive_or_data_pin_oe
);
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] dv_r;
  logic wr;
  logic rd;
  logic map;
  logic ck;
  logic dt;

  // Decoded bus events and short names for the pin enables.
  assign wr = psel && penable && pready && pwrite && ce;
  assign rd = pready && !pwrite;
  assign ck = transmit_or_clock_pin_oe;
  assign dt = receive_or_data_pin_oe;
  assign map = paddr inside {`USC_OFS_TXSC, `USC_OFS_RXSC, `USC_OFS_DIV,
    `USC_OFS_TXDATA, `USC_OFS_RXDATA};

  // Mirror of what software wrote; status bits are masked where compared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      dv_r <= 8'h00;
    end else if (wr) begin
      if (paddr == `USC_OFS_TXSC) tx_r <= pwdata[7:0];
      if (paddr == `USC_OFS_RXSC) rx_r <= pwdata[7:0];
      if (paddr == `USC_OFS_DIV) dv_r <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rdy;
    psel && !penable && ce ##1 ce |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access cycle");
  property p_err;
    pready |-> (pslverr == !map) && (map || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_rdtx;
    rd && paddr == `USC_OFS_TXSC |-> prdata[7:4] == tx_r[7:4] && prdata[3:2] ==
      {1'b0, tx_r[2]} && prdata[0] == tx_r[0] && prdata[31:8] == 24'h0;
  endproperty
  a_rdtx: assert property (p_rdtx) else $error("tx control mismatch");
  property p_rdrx;
    rd && paddr == `USC_OFS_RXSC |-> {prdata[7:6], prdata[4:3]} == {rx_r[7:6], rx_r[4:3]};
  endproperty
  a_rdrx: assert property (p_rdrx) else $error("rx control mismatch");
  property p_dv;
    rd && paddr == `USC_OFS_DIV |-> prdata == {24'h0, dv_r};
  endproperty
  a_dv: assert property (p_dv) else $error("divisor mismatch");
  property p_overrun_error;
    rd && paddr == `USC_OFS_RXSC && !rx_r[4] && !$past(rx_r[4]) |-> !prdata[1];
  endproperty
  a_overrun_error: assert property (p_overrun_error) else $error("overrun kept");
  property p_off;
    (!rx_r[7]) [*3] |-> !ck && !dt;
  endproperty
  a_off: assert property (p_off) else $error("pins driven while off");
  property p_async;
    (rx_r[7] && !tx_r[4]) [*3] |-> ck && !dt;
  endproperty
  a_async: assert property (p_async) else $error("async pin use");
  property p_master;
    (rx_r[7] && tx_r[4] && tx_r[7]) [*3] |-> ck;
  endproperty
  a_master: assert property (p_master) else $error("master clock off");
  property p_slave;
    (rx_r[7] && tx_r[4] && !tx_r[7]) [*3] |-> !ck;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock");

  // Main scenarios reached.
  c_tx: cover property (wr && paddr == `USC_OFS_TXDATA);
  c_err: cover property (pready && pslverr);
  c_sync: cover property (rx_r[7] && tx_r[4] && ck);
endmodule

bind usc_top usc_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .transmit_or_clock_pin_oe(transmit_or_clock_pin_oe),
  .receive_or_data_pin_oe(receive_or_data_pin_oe)
);

// [usc_peer.sv]
`timescale 1ns/1ps

// Terminal at the far end of the asynchronous link; its line idles high.
module usc_peer (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;

  // Holds each bit for a whole bit time, so all votes agree.
  task automatic send(input int bt, input int n, input logic [8:0] v, input logic stp);
    line_out <= 1'b0;
    repeat (bt) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (bt) @(posedge pclk);
    end
    line_out <= stp;
    repeat (bt) @(posedge pclk);
    line_out <= 1'b1;
    // One idle clock, so a following frame never drives the line in the same step.
    @(posedge pclk);
  endtask

  // Samples n bits and the stop bit at their centres after a start edge.
  task automatic recv(input int bt, input int n, output logic [9:0] v);
    int k;
    v = '0;
    k = 0;
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i <= n; i++) begin
      repeat (bt) @(posedge pclk);
      v[i] = line_in;
    end
  endtask
endmodule

// [usc_top_test.sv]
`timescale 1ns/1ps
`include "usc_params.svh"

// Drives the port over APB and a terminal model over the serial pins.
module usc_top_test;
  localparam logic [7:0] o_tx = `USC_OFS_TXSC;
  localparam logic [7:0] o_rx = `USC_OFS_RXSC;
  localparam logic [7:0] o_dv = `USC_OFS_DIV;
  localparam logic [7:0] o_td = `USC_OFS_TXDATA;
  localparam logic [7:0] o_rd = `USC_OFS_RXDATA;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready, pslverr, se, tck_o, tck_oe, tck, rdt_o, rdt_oe, rdt, pout;
  logic [9:0] v;
  logic [7:0] cf [2] = '{8'h24, 8'h61};
  logic [7:0] dv [2] = '{8'h01, 8'h00};
  logic [7:0] dat [2] = '{8'ha5, 8'h3c};
  logic [9:0] ex [2] = '{10'h1a5, 10'h33c};
  int bt [2] = '{32, 64};
  int nb [2] = '{8, 9};
  int errors = 0;
  int checked = 0;

  // Released pins: the clock line is pulled up, the data line follows the peer.
  assign tck = tck_oe ? tck_o : 1'b1;
  assign rdt = rdt_oe ? rdt_o : pout;

  usc_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_or_clock_pin_i(tck), .transmit_or_clock_pin_o(tck_o),
    .transmit_or_clock_pin_oe(tck_oe), .receive_or_data_pin_i(rdt),
    .receive_or_data_pin_o(rdt_o), .receive_or_data_pin_oe(rdt_oe));
  usc_peer PEER (.pclk(pclk), .line_in(tck), .line_out(pout));

  // 50 MHz clock.
  initial forever #10 pclk = ~pclk;

  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(o_tx, 32'h02);
    rd(o_rx, 32'h00);
    rd(o_dv, 32'h00);
    apb(1'b1, 8'h14, 32'hff);
    chk({31'h0, se}, 32'h1);
    rd(8'h14, 32'h0);
    apb(1'b1, o_tx, 32'hff);
    rd(o_tx, 32'hf7);
    apb(1'b1, o_dv, 32'h5a);
    rd(o_dv, 32'h5a);
    apb(1'b1, o_tx, 32'h00);
    $display("test registers done");
    // Async transmit at both speeds and frame widths; busy clears shift-empty.
    apb(1'b1, o_rx, 32'h80);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, o_dv, {24'h0, dv[i]});
      apb(1'b1, o_tx, {24'h0, cf[i]});
      apb(1'b1, o_td, {24'h0, dat[i]});
      rd(o_tx, {24'h0, cf[i]});
      PEER.recv(bt[i], nb[i], v);
      chk({22'h0, v}, {22'h0, ex[i]});
      repeat (bt[i]) @(posedge pclk);
      rd(o_tx, {24'h0, cf[i] | 8'h02});
    end
    $display("test transmit done");
    // Async receive, address detect, overrun, then framing error last.
    apb(1'b1, o_tx, 32'h04);
    apb(1'b1, o_dv, 32'h01);
    apb(1'b1, o_rx, 32'h90);
    PEER.send(32, 8, 9'h0c3, 1'b1);
    rd(o_rd, 32'h1c3);
    rd(o_rx, 32'h90);
    apb(1'b1, o_rx, 32'hd8);
    PEER.send(32, 9, 9'h055, 1'b1);
    apb(1'b0, o_rd, 32'h0);
    chk(r & 32'h100, 32'h0);
    PEER.send(32, 9, 9'h1aa, 1'b1);
    rd(o_rd, 32'h1aa);
    rd(o_rx, 32'hd9);
    apb(1'b1, o_rx, 32'h90);
    PEER.send(32, 8, 9'h011, 1'b1);
    PEER.send(32, 8, 9'h022, 1'b1);
    rd(o_rx, 32'h92);
    rd(o_rd, 32'h111);
    apb(1'b1, o_rx, 32'h80);
    rd(o_rx, 32'h80);
    apb(1'b1, o_rx, 32'h90);
    PEER.send(32, 8, 9'h077, 1'b0);
    rd(o_rx, 32'h94);
    apb(1'b1, o_rx, 32'h00);
    apb(1'b0, o_rd, 32'h0);
    $display("test receive done");
    // Sync master single receive ends by itself; high speed has no effect.
    apb(1'b1, o_tx, 32'h94);
    apb(1'b1, o_dv, 32'h00);
    apb(1'b1, o_rx, 32'ha0);
    apb(1'b0, o_rx, 32'h0);
    for (int k = 0; k < 30 && r[5] !== 1'b0; k++) apb(1'b0, o_rx, 32'h0);
    chk(r & 32'h20, 32'h0);
    rd(o_rd, 32'h1ff);
    // Sync master transmit: each data bit stands while our clock is high.
    apb(1'b1, o_tx, 32'hb0);
    apb(1'b1, o_rx, 32'h80);
    apb(1'b1, o_td, 32'h96);
    v = '0;
    for (int i = 0; i < 8; i++) begin
      do begin
        @(posedge pclk);
      end while (tck !== 1'b1);
      v[i] = rdt;
      do begin
        @(posedge pclk);
      end while (tck !== 1'b0);
    end
    chk({22'h0, v}, 32'h96);
    apb(1'b1, o_tx, 32'h10);
    apb(1'b1, o_rx, 32'h00);
    $display("test sync done");
    give_verdict();
  end
endmodule
